// *** src/acp_host_ctrl.sv ***
// Host-side serial audio controller: drives clocks and data into the codec's playback
// port and receives the record port, both ports slaved to the clocks made here.
// Assumes one AHB-Lite master, word accesses only, and the codec set to slave mode.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
module acp_host_ctrl (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Playback port pins
    output logic             playback1_master_clock,
    output logic             playback1_bit_clock,
    output logic             playback1_frame_clock,
    output logic             playback1_serial_input,
    // Record port pins
    output logic             record_master_clock,
    output logic             record_bit_clock,
    output logic             record_frame_clock,
    input  wire logic        record_serial_output
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        acp_pkg::acp_state_t st;
        logic [10:0]         cfg;
        logic                enable;
        logic                rec_en;
        logic [31:0]         txl;
        logic [31:0]         txr;
        logic [31:0]         shl;
        logic [31:0]         shr;
        logic [31:0]         rxl;
        logic [31:0]         rxr;
        logic [31:0]         sftl;
        logic [31:0]         sftr;
        logic                tx_req;
        logic                rx_val;
        logic [2:0]          ph;
        logic [8:0]          bitn;
        logic                mclk;
        logic                bclk;
        logic                lrclk;
        logic                sdo;
        logic                sync1;
        logic                sync2;
        logic [31:0]         hrdata;
        logic                hreadyout;
        logic                ap_wr;
        logic [7:0]          ap_addr;
    } acp_regs_t;

    acp_regs_t   r;
    acp_regs_t   n;

    logic [1:0]  fmt;
    logic [1:0]  wl_code;
    logic        bcp;
    logic        lrp;
    logic        dspb;
    logic [2:0]  ratio;
    logic [5:0]  wl;
    logic [8:0]  half;
    logic [8:0]  last;
    logic        cfg_ok;
    logic        take;

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding functions

    // Word length code to bit count
    function automatic logic [5:0] wl_bits(input logic [1:0] c);
        logic [5:0] v;
        unique case (c)
            2'h0:    v = acp_pkg::WL16_BITS;
            2'h1:    v = acp_pkg::WL20_BITS;
            2'h2:    v = acp_pkg::WL24_BITS;
            default: v = acp_pkg::WL32_BITS;
        endcase
        return v;
    endfunction

    // Bit clocks per half frame; zero for the auto code, which a clock source cannot use
    function automatic logic [8:0] half_bits(input logic [2:0] c);
        logic [10:0] fs;
        unique case (c)
            3'h1:    fs = acp_pkg::FS128;
            3'h2:    fs = acp_pkg::FS192;
            3'h3:    fs = acp_pkg::FS256;
            3'h4:    fs = acp_pkg::FS384;
            3'h5:    fs = acp_pkg::FS512;
            3'h6:    fs = acp_pkg::FS768;
            3'h7:    fs = acp_pkg::FS1152;
            default: fs = '0;
        endcase
        return 9'(fs >> acp_pkg::HALF_SHIFT);
    endfunction

    // Which channel and bit a given bit clock slot carries, MSB counted as index 0
    function automatic acp_pkg::acp_slot_t find_slot(
        input logic [1:0] f,
        input logic       b_mode,
        input logic [5:0] w,
        input logic [8:0] h,
        input logic [8:0] b
    );
        logic [9:0]         sl;
        logic [9:0]         sr;
        logic [9:0]         bb;
        acp_pkg::acp_slot_t s;
        s  = '0;
        bb = {1'b0, b};
        unique case (f)
            acp_pkg::FMT_RJ:
            begin
                sl = {1'b0, h} - {4'h0, w};
                sr = {h, 1'b0} - {4'h0, w};
            end
            acp_pkg::FMT_LJ:
            begin
                sl = '0;
                sr = {1'b0, h};
            end
            acp_pkg::FMT_I2S:
            begin
                sl = acp_pkg::I2S_DELAY;
                sr = {1'b0, h} + acp_pkg::I2S_DELAY;
            end
            default:
            begin
                sl = b_mode ? '0 : acp_pkg::DSPA_DELAY;
                sr = sl + {4'h0, w};
            end
        endcase
        if (bb >= sl && bb < sl + {4'h0, w})
        begin
            s.act = 1'b1;
            s.idx = 5'(bb - sl);
        end
        else if (bb >= sr && bb < sr + {4'h0, w})
        begin
            s.act   = 1'b1;
            s.right = 1'b1;
            s.idx   = 5'(bb - sr);
        end
        return s;
    endfunction

    // Frame clock level before polarity, per format and slot
    function automatic logic frame_level(
        input logic [1:0] f,
        input logic [8:0] h,
        input logic [8:0] b
    );
        logic v;
        unique case (f)
            acp_pkg::FMT_I2S: v = (b >= h);
            acp_pkg::FMT_DSP: v = (b == '0);
            default:          v = (b < h);
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration fields and their legality

    assign fmt     = r.cfg[acp_pkg::CFG_FMT_LO +: 2];
    assign wl_code = r.cfg[acp_pkg::CFG_WL_LO +: 2];
    assign bcp     = r.cfg[acp_pkg::CFG_BCP];
    assign lrp     = r.cfg[acp_pkg::CFG_LRP];
    assign dspb    = r.cfg[acp_pkg::CFG_DSPB];
    assign ratio   = r.cfg[acp_pkg::CFG_RATIO_LO +: 3];
    assign wl      = wl_bits(wl_code);
    assign half    = half_bits(ratio);
    assign last    = 9'({half, 1'b0} - 10'h001);
    assign take    = hsel & htrans[1] & hready;

    // Refuse to start a frame the codec could not decode
    always_comb
    begin
        cfg_ok = (ratio != acp_pkg::RATIO_AUTO);
        cfg_ok = cfg_ok && (half > {3'h0, wl});
        cfg_ok = cfg_ok && !(fmt == acp_pkg::FMT_RJ && wl_code == acp_pkg::WL_32);
        if (r.rec_en)
        begin
            cfg_ok = cfg_ok && ratio >= acp_pkg::REC_RATIO_MIN;
            cfg_ok = cfg_ok && ratio <= acp_pkg::REC_RATIO_MAX;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        acp_pkg::acp_slot_t s;
        logic [8:0]         nb;
        logic               wrap;
        logic               fend;
        logic [31:0]        word;
        logic [5:0]         k;
        n    = r;
        s    = '0;
        nb   = r.bitn;
        word = '0;
        k    = '0;
        wrap = (r.ph == acp_pkg::PH_LAST);
        fend = wrap && (r.bitn == last);

        // Record data pin through two flops before anything reads it
        n.sync1 = record_serial_output;
        n.sync2 = r.sync1;

        // Address phase: read data is prepared here so it leaves a flop, zero waits
        n.hreadyout = 1'b1;
        n.ap_wr     = take & hwrite;
        n.ap_addr   = haddr[7:0];
        if (take && !hwrite)
        begin
            unique case (haddr[7:0])
                acp_pkg::ADDR_CFG:  n.hrdata = 32'(r.cfg);
                acp_pkg::ADDR_CTRL: n.hrdata = 32'({r.rec_en, r.enable});
                acp_pkg::ADDR_STAT: n.hrdata = 32'({!cfg_ok, r.rx_val, r.tx_req,
                                                    r.st == acp_pkg::ST_RUN});
                acp_pkg::ADDR_TXL:  n.hrdata = r.txl;
                acp_pkg::ADDR_TXR:  n.hrdata = r.txr;
                acp_pkg::ADDR_RXL:  n.hrdata = r.rxl;
                acp_pkg::ADDR_RXR:  n.hrdata = r.rxr;
                default:            n.hrdata = '0;
            endcase
        end

        // Data phase writes; flag clears come first so a same-cycle set still wins
        if (r.ap_wr)
        begin
            unique case (r.ap_addr)
                acp_pkg::ADDR_CFG:
                begin
                    if (r.st == acp_pkg::ST_IDLE && !r.enable)
                        n.cfg = hwdata[acp_pkg::CFG_W-1:0];
                end
                acp_pkg::ADDR_CTRL:
                begin
                    n.enable = hwdata[acp_pkg::CTRL_EN];
                    n.rec_en = hwdata[acp_pkg::CTRL_REC];
                end
                acp_pkg::ADDR_STAT:
                begin
                    if (hwdata[acp_pkg::STAT_TXREQ])
                        n.tx_req = 1'b0;
                    if (hwdata[acp_pkg::STAT_RXVAL])
                        n.rx_val = 1'b0;
                end
                acp_pkg::ADDR_TXL: n.txl = hwdata;
                acp_pkg::ADDR_TXR: n.txr = hwdata;
                default:
                begin
                end
            endcase
        end

        // Serial engine; every port clock comes from one counter so they stay locked
        unique case (r.st)
            acp_pkg::ST_IDLE:
            begin
                n.mclk  = 1'b0;
                n.bclk  = 1'b1 ^ bcp;
                n.lrclk = lrp;
                n.sdo   = 1'b0;
                if (r.enable && cfg_ok)
                begin
                    n.st   = acp_pkg::ST_RUN;
                    n.ph   = acp_pkg::PH_LAST;   // First advance lands on slot 0
                    n.bitn = last;
                end
            end
            acp_pkg::ST_RUN:
            begin
                n.mclk = ~r.mclk;      // fixed hclk/2 keeps fs far below limits
                n.ph   = 3'(r.ph + 3'h1);

                // Record data sampled two cycles after the rising edge, the sync delay
                if (r.ph == acp_pkg::PH_SAMPLE)
                begin
                    s = find_slot(fmt, dspb, wl, half, r.bitn);
                    if (s.act && !s.right)
                        n.sftl = (s.idx == '0) ? 32'(r.sync2) : {r.sftl[30:0], r.sync2};
                    if (s.act && s.right)
                        n.sftr = (s.idx == '0) ? 32'(r.sync2) : {r.sftr[30:0], r.sync2};
                end

                // End of frame hands both received words over at once
                if (fend && r.rec_en)
                begin
                    n.rxl    = n.sftl;
                    n.rxr    = n.sftr;
                    n.rx_val = 1'b1;
                end

                if (fend && !r.enable)
                begin
                    // Stopping only at a frame boundary keeps the last frame whole
                    n.st    = acp_pkg::ST_IDLE;
                    n.mclk  = 1'b0;
                    n.bclk  = 1'b1 ^ bcp;
                    n.lrclk = lrp;
                    n.sdo   = 1'b0;
                end
                else
                begin
                    nb     = wrap ? (fend ? '0 : 9'(r.bitn + 9'h001)) : r.bitn;
                    n.bitn = nb;
                    n.bclk = (n.ph >= acp_pkg::PH_RISE) ^ bcp;
                    if (wrap)
                    begin
                        // Falling edge: frame clock and data move together
                        n.lrclk = frame_level(fmt, half, nb) ^ lrp;
                        if (nb == '0)
                        begin
                            n.shl    = r.txl;
                            n.shr    = r.txr;
                            n.tx_req = 1'b1;
                        end
                        s    = find_slot(fmt, dspb, wl, half, nb);
                        word = s.right ? n.shr : n.shl;
                        k    = 6'(wl - 6'h01 - {1'b0, s.idx});
                        n.sdo = s.act ? word[k[4:0]] : 1'b0;
                    end
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r           <= '0;
            r.cfg       <= acp_pkg::CFG_RESET;
            r.bclk      <= 1'b1;
            r.hreadyout <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flop except hresp, tied to OKAY; both ports share one clock set

    assign hrdata                 = r.hrdata;
    assign hreadyout              = r.hreadyout;
    assign hresp                  = 1'b0;   // Always OKAY
    assign playback1_master_clock = r.mclk;
    assign playback1_bit_clock    = r.bclk;
    assign playback1_frame_clock  = r.lrclk;
    assign playback1_serial_input = r.sdo;
    assign record_master_clock    = r.mclk;
    assign record_bit_clock       = r.bclk;
    assign record_frame_clock     = r.lrclk;

endmodule // acp_host_ctrl

// *** src/acp_pkg.sv ***
// Constants, field layouts and types for the audio codec port host controller.
// Assumes a 10 MHz hclk; the codec's playback and record ports are slaves to our clocks.
//
// Contract
// - Master clock must stay synchronised with its frame clock; jitter is tolerated.
// - Record port: no ratio above 384fs at 88.2 kHz; only 256fs at 96 kHz.
// - Playback at 176.4/192 kHz uses 128/192fs; 32 kHz needs 256fs+; 1152fs only there.
// - All formats send MSB first; words 16/20/24/32 bits; no 32-bit right-justified.
// - I2S/LJ/RJ frame clock high and low each for at least word-length bit clocks.
// - DSP: both words on one line, rising frame edge marks MSB, frame >= 2 words.
// - I2S: MSB sampled on second rising bit clock edge, driven on first falling edge.
// - I2S: frame clock low carries left channel, high carries right channel.
// - LJ: MSB driven on the transition's falling edge; frame clock high means left.
// - RJ: LSB sampled on the rising edge just before the frame clock transition.
// - DSP A: left MSB on second rising edge after frame rise; right follows directly.
// - DSP B: left MSB on first rising edge after frame rise; right follows directly.
// - Format may only be changed while the port is idle.
package acp_pkg;

    // Own register map on AHB-Lite, byte addresses
    localparam logic [7:0]  ADDR_CFG      = 8'h00;
    localparam logic [7:0]  ADDR_CTRL     = 8'h04;
    localparam logic [7:0]  ADDR_STAT     = 8'h08;
    localparam logic [7:0]  ADDR_TXL      = 8'h0c;
    localparam logic [7:0]  ADDR_TXR      = 8'h10;
    localparam logic [7:0]  ADDR_RXL      = 8'h14;
    localparam logic [7:0]  ADDR_RXR      = 8'h18;

    // Configuration register layout (11 bits used)
    localparam int          CFG_W         = 11;
    localparam int          CFG_FMT_LO    = 0;
    localparam int          CFG_WL_LO     = 2;
    localparam int          CFG_BCP       = 4;
    localparam int          CFG_LRP       = 5;
    localparam int          CFG_DSPB      = 6;
    localparam int          CFG_RATIO_LO  = 8;
    localparam logic [10:0] CFG_RESET     = 11'h30a;
    localparam int          CTRL_EN       = 0;
    localparam int          CTRL_REC      = 1;
    localparam int          STAT_RUN      = 0;
    localparam int          STAT_TXREQ    = 1;
    localparam int          STAT_RXVAL    = 2;
    localparam int          STAT_CFGERR   = 3;

    // Format and word length codes
    localparam logic [1:0]  FMT_RJ        = 2'h0;
    localparam logic [1:0]  FMT_LJ        = 2'h1;
    localparam logic [1:0]  FMT_I2S       = 2'h2;
    localparam logic [1:0]  FMT_DSP       = 2'h3;
    localparam logic [1:0]  WL_32         = 2'h3;
    localparam logic [5:0]  WL16_BITS     = 6'h10;
    localparam logic [5:0]  WL20_BITS     = 6'h14;
    localparam logic [5:0]  WL24_BITS     = 6'h18;
    localparam logic [5:0]  WL32_BITS     = 6'h20;

    // Ratio codes and master clocks per frame
    localparam logic [2:0]  RATIO_AUTO    = 3'h0;
    localparam logic [2:0]  REC_RATIO_MIN = 3'h3;
    localparam logic [2:0]  REC_RATIO_MAX = 3'h6;
    localparam logic [10:0] FS128         = 11'h080;
    localparam logic [10:0] FS192         = 11'h0c0;
    localparam logic [10:0] FS256         = 11'h100;
    localparam logic [10:0] FS384         = 11'h180;
    localparam logic [10:0] FS512         = 11'h200;
    localparam logic [10:0] FS768         = 11'h300;
    localparam logic [10:0] FS1152        = 11'h480;

    // Timing: master clock is hclk/2, bit clock is master clock/4 (8 hclk cycles)
    localparam int          HCLK_NS       = 100;
    localparam int          BCLK_NS       = 800;
    localparam int          BCLK_CYC      = BCLK_NS / HCLK_NS;
    localparam logic [2:0]  PH_LAST       = 3'(BCLK_CYC - 1);
    localparam logic [2:0]  PH_RISE       = 3'(BCLK_CYC / 2);
    localparam logic [2:0]  PH_SAMPLE     = 3'(BCLK_CYC / 2 + 2);
    localparam int          HALF_SHIFT    = 3;
    localparam logic [9:0]  I2S_DELAY     = 10'h001;
    localparam logic [9:0]  DSPA_DELAY    = 10'h001;

    // Codec register map, written by software over the codec's control port
    localparam logic [6:0]  DEV_PB1_FORMAT = 7'h02;
    localparam logic [6:0]  DEV_PB1_RATIO  = 7'h03;
    localparam logic [6:0]  DEV_PB2_RATIO  = 7'h08;
    localparam logic [6:0]  DEV_REC_RATIO  = 7'h0e;
    localparam logic [6:0]  DEV_REC_MASTER = 7'h0f;
    localparam int          DEV_REC_MASTER_BIT = 0;

    typedef enum logic {ST_IDLE, ST_RUN} acp_state_t;

    typedef struct packed {
        logic       act;
        logic       right;
        logic [4:0] idx;
    } acp_slot_t;

endpackage

// *** dv/acp_host_ctrl_checker.sv ***
// Checker: bus answer, serial clock shapes and hold times at the pins.
// Bound to the controller; sees its ports only, one hclk domain.
`timescale 1ns/1ps
module acp_chk (
    // Clock, reset and bus answer
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    // Serial pins
    input wire logic playback1_master_clock,
    input wire logic playback1_bit_clock,
    input wire logic playback1_frame_clock,
    input wire logic playback1_serial_input,
    input wire logic record_master_clock,
    input wire logic record_bit_clock,
    input wire logic record_frame_clock
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////
    // A bit clock half is four hclk whatever the polarity
    sequence s_low4; !playback1_bit_clock [*4]; endsequence
    sequence s_high4; playback1_bit_clock [*4]; endsequence
    property p_okay; hreadyout && !hresp; endproperty
    property p_idle; $rose(hresetn) |-> playback1_bit_clock && !playback1_master_clock
        && !playback1_frame_clock; endproperty
    property p_mclk; $rose(playback1_master_clock) |=> !playback1_master_clock; endproperty
    property p_low; $fell(playback1_bit_clock) |-> s_low4; endproperty
    property p_high; $rose(playback1_bit_clock) |-> s_high4; endproperty
    // Frame and data stand a whole bit clock, so the codec never sees a glitch
    property p_frame; $changed(playback1_frame_clock) |=>
        $stable(playback1_frame_clock) [*7]; endproperty
    property p_data; $changed(playback1_serial_input) |=>
        $stable(playback1_serial_input) [*7]; endproperty
    property p_copy; record_bit_clock == playback1_bit_clock
        && record_master_clock == playback1_master_clock
        && record_frame_clock == playback1_frame_clock; endproperty
    a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
    a_idle: assert property (p_idle) else $error("pins not idle after reset");
    a_mclk: assert property (p_mclk) else $error("master clock high too long");
    a_low: assert property (p_low) else $error("bit clock low half short");
    a_high: assert property (p_high) else $error("bit clock high half short");
    a_frame: assert property (p_frame) else $error("frame clock moved early");
    a_data: assert property (p_data) else $error("data moved within a bit");
    a_copy: assert property (p_copy) else $error("record clocks differ");
endmodule // acp_chk
bind acp_host_ctrl acp_chk u_chk (.*);

// *** dv/acp_codec_model.sv ***
// Codec serial port model in slave mode: logs each rise of the bit clock with polarity undone.
// Assumes the controller makes all clocks; one bench bit sets both polarities.
`timescale 1ns/1ps
module acp_codec_model (
    // Pins from the controller
    input wire logic bit_clock,   // Slave port: clocks come in, divider unused
    input wire logic frame_clock,
    input wire logic serial_in,
    input wire logic bcp,
    // Record data back
    output logic     serial_out
);
    logic        bk;
    logic [31:0] pat;
    logic        qf[$], qd[$], qo[$];
    // Inverted bit clock moves the latch to the falling pin edge
    assign bk = bit_clock ^ bcp;
    initial serial_out = 1'b0;
    // Frame clock (polarity undone) and data latched on the rise, MSB first
    always @(posedge bk)
    begin
        qf.push_back(frame_clock ^ bcp);
        qd.push_back(serial_in);
        qo.push_back(serial_out);
    end
    // Output moves on the fall; a rotating word keeps bits varied
    always @(negedge bk)
    begin
        serial_out <= pat[31];
        pat <= {pat[30:0], pat[31]};
    end
    task automatic clear;
        qf.delete();
        qd.delete();
        qo.delete();
    endtask
endmodule // acp_codec_model

// *** dv/testbench.sv ***
// Bench: AHB-Lite register traffic, frames decoded from codec samples.
// Assumes the controller masters all serial clocks; one bus master.
`timescale 1ns/1ps
module testbench;
    logic        hclk, hresetn, hsel, hwrite, hready, hresp, bcp;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, seed, q;
    logic        pm, pb, pf, pd, rm, rb, rf, rd;
    int          fail_count, checks_done, k;
    int          rt[8] = '{0, 128, 192, 256, 384, 512, 768, 1152};
    int          wb[4] = '{16, 20, 24, 32};
    acp_host_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .playback1_master_clock(pm),
        .playback1_bit_clock(pb), .playback1_frame_clock(pf), .playback1_serial_input(pd),
        .record_master_clock(rm), .record_bit_clock(rb), .record_frame_clock(rf),
        .record_serial_output(rd));
    acp_codec_model u_codec (.bit_clock(pb), .frame_clock(pf), .serial_in(pd), .bcp(bcp),
        .serial_out(rd));
    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    ////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("mismatches %0d comparisons %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] lf(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Waits for ready; a stuck bus ends the run
    task automatic wt;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hready !== 1'b1 && n < 100);
        if (n >= 100)
        begin
            fail_count++;
            summarize();
        end
    endtask
    // One single word transfer; the leading edge leaves an idle cycle between transfers
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wt();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wt();
        q = hrdata;
    endtask
    // Slot of a word from frame start
    function automatic int off(logic [1:0] f, logic db, int wl, int hf, int r);
        case (f)
            2'h0: return r ? 2 * hf - wl : hf - wl;
            2'h1: return r ? hf : 0;
            2'h2: return r ? hf + 1 : 1;
            default: return db ? r * wl : r * wl + 1;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////
    task automatic run(logic [1:0] f, logic [1:0] w, logic b, logic db, logic [2:0] r,
                       logic rec);
        logic [31:0] tl, tr, t, x, m, c;
        logic        err;
        int          wl, fr, st, ps, o, i, j, n;
        wl = wb[w];
        fr = rt[r] / 4;
        m = 32'((64'h1 << wl) - 1);
        c = {21'h0, r, 1'b0, db, b, b, w, f};
        err = r == acp_pkg::RATIO_AUTO || fr / 2 <= wl || (f == 2'h0 && w == 2'h3)
            || (rec && (r < acp_pkg::REC_RATIO_MIN || r > acp_pkg::REC_RATIO_MAX));
        tl = seed;
        tr = lf(seed);
        seed = lf(tr);
        bus(1'b1, acp_pkg::ADDR_STAT, 32'h6); // Flags of earlier runs cleared
        bus(1'b1, acp_pkg::ADDR_TXL, tl);
        bus(1'b1, acp_pkg::ADDR_TXR, tr);
        bus(1'b1, acp_pkg::ADDR_CFG, c);
        repeat (8) @(posedge hclk); // Idle pins settle a whole bit before start
        bcp <= b;
        u_codec.pat = seed;
        u_codec.clear();
        bus(1'b1, acp_pkg::ADDR_CTRL, {30'h0, rec, 1'b1});
        bus(1'b0, acp_pkg::ADDR_STAT, 32'h0);
        chk({q[3], q[0]}, {err, !err});
        bus(1'b1, acp_pkg::ADDR_CFG, 32'h0);
        bus(1'b0, acp_pkg::ADDR_CFG, 32'h0);
        chk(q, c);
        if (!err)
            repeat (fr * 24) @(posedge hclk);
        bus(1'b1, acp_pkg::ADDR_CTRL, 32'h0);
        n = 0;
        do
            bus(1'b0, acp_pkg::ADDR_STAT, 32'h0);
        while (q[0] !== 1'b0 && ++n < 1000);
        chk(q[2:0], err ? 3'h0 : {rec, 2'h2});
        if (n >= 1000)
            summarize();
        if (err)
            return;
        st = -1;
        ps = -1;
        for (i = 1; i < u_codec.qf.size(); i++)
            if (u_codec.qf[i] !== u_codec.qf[i-1] && u_codec.qf[i] === (f != 2'h2))
            begin
                ps = st;
                st = i;
            end
        chk(u_codec.qf.size() - st, fr);
        chk(st - ps, fr);
        for (i = 0; i < 2; i++)
        begin
            o = st + off(f, db, wl, fr / 2, i);
            t = 32'h0;
            x = 32'h0;
            for (j = 0; j < wl; j++)
            begin
                t = {t[30:0], u_codec.qd[o + j]};
                x = {x[30:0], u_codec.qo[o + j]};
            end
            chk(t, (i ? tr : tl) & m);
            bus(1'b0, i ? acp_pkg::ADDR_RXR : acp_pkg::ADDR_RXL, 32'h0);
            if (rec)
                chk(q & m, x);
        end
    endtask
    ////////////////////////////////////////////////////////////
    // Reset, register defaults, then frames in every format
    initial
    begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata, bcp} = '0;
        seed = 32'h35;
        fail_count = 0;
        checks_done = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, acp_pkg::ADDR_CFG, 32'h0);
        chk(q, 32'h30a);
        bus(1'b1, 8'h1c, 32'hffffffff);
        bus(1'b0, 8'h1c, 32'h0);
        chk(q, 32'h0);
        run(2'h2, 2'h0, 1'b0, 1'b0, 3'h2, 1'b0);
        for (k = 0; k < 5; k++)
        begin
            run(k > 3 ? 2'h3 : 2'(k), 2'(seed % 3), seed[7], k == 4, 3'(3 + seed % 4), 1'b1);
            seed = lf(seed);
        end
        run(2'h3, 2'h3, 1'b1, 1'b0, 3'h7, 1'b0);
        run(2'h0, 2'h3, 1'b0, 1'b0, 3'h4, 1'b0);
        run(2'h2, 2'h0, 1'b0, 1'b0, 3'h0, 1'b0);
        run(2'h1, 2'h0, 1'b0, 1'b0, 3'h1, 1'b1);
        summarize();
    end
endmodule // testbench
